// >>> rtl/queued_serial_status_control.sv
`timescale 1ns/1ns
`default_nettype none
module queued_serial_status_control (
	input  wire logic        aclk,          // system clock
	input  wire logic        aresetn,       // sync reset, active low
	input  wire logic [7:0]  s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // write strobes
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write response
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response ready
	input  wire logic [7:0]  s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read response
	output logic             s_axi_rvalid,  // read data valid
	input  wire logic        s_axi_rready,  // read data ready
	input  wire logic        sck_in,        // link clock from pin
	input  wire logic        miso_in,       // serial data in
	input  wire logic        ss_n_in,       // slave-select input
	output logic             irq            // level interrupt
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [4:0] nbits(input logic [3:0] f);
		nbits = (f == 4'h0) ? 5'(sq_pkg::NBITS_DEFAULT)
			: f[3] ? {2'b01, f[2:0]} : 5'(sq_pkg::NBITS_DEFAULT);
	endfunction
	function automatic logic [15:0] rjust(input logic [15:0] v,
		input logic [4:0] n);
		rjust = v & 16'(({17'h1} << n) - 17'h1);
	endfunction

	// pin synchronisers
	logic [1:0] sck_sy_q, miso_sy_q, ss_sy_q;
	logic       sck_prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_sy_q   <= 2'h0;
			miso_sy_q  <= 2'h0;
			ss_sy_q    <= 2'h3;
			sck_prev_q <= 1'b0;
		end else begin
			sck_sy_q   <= {sck_sy_q[0], sck_in};
			miso_sy_q  <= {miso_sy_q[0], miso_in};
			ss_sy_q    <= {ss_sy_q[0], ss_n_in};
			sck_prev_q <= sck_sy_q[1];
		end
	end
	wire sck_rise = sck_sy_q[1] & ~sck_prev_q;

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  ctrl3_q;
	logic [22:0] qcfg_q;
	logic [2:0]  imask_q;
	sq_pkg::flags_s flags_q;
	logic [3:0]  completed_cmd_pointer_q, cur_q;
	logic [15:0] rx_ram_q [16];
	logic [15:0] shift_q;
	logic [4:0]  bitcnt_q;
	logic [13:0] dly_q;
	sq_pkg::q_state_e st_q;

	wire        halt_req  = ctrl3_q[sq_pkg::CTL_HALT];
	wire        irq_en    = ctrl3_q[sq_pkg::CTL_HFIE];
	wire [3:0]  endq      = qcfg_q[sq_pkg::QC_ENDQ +: 4];
	wire [7:0]  post_transfer_delay_length       = qcfg_q[sq_pkg::QC_DTL +: 8];
	wire [3:0]  bits_f    = qcfg_q[sq_pkg::QC_BITS +: 4];
	wire        dt_sel    = qcfg_q[sq_pkg::QC_DT];
	wire        master_select_bit      = qcfg_q[sq_pkg::QC_MASTER_SELECT_BIT];
	wire        q_en      = qcfg_q[sq_pkg::QC_EN];
	wire [4:0]  n_bits    = nbits(bits_f);
	wire [13:0] dly_load  = !dt_sel ? 14'(sq_pkg::STD_DELAY_CLKS)
		: (post_transfer_delay_length == 8'h00) ? 14'(sq_pkg::DTL_ZERO_CLKS)
		: 14'(sq_pkg::DTL_SCALE) * {6'h0, post_transfer_delay_length};
	wire        xfer_done = (st_q == sq_pkg::ST_XFER) && sck_rise
		&& (bitcnt_q == n_bits - 5'h1);
	wire        cmd_done  = (st_q == sq_pkg::ST_DELAY) && (dly_q == 14'h1);
	wire        last_cmd  = cur_q == endq;
	wire        ev_fin    = cmd_done && last_cmd;
	wire        ev_halt_ack_flag  = cmd_done && last_cmd && halt_req;
	wire        ev_mode_fault_flag   = master_select_bit && q_en && !ss_sy_q[1];

	////////////////////////////////////////////////////////////////////////
	// queue sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q     <= sq_pkg::ST_IDLE;
			cur_q    <= 4'h0;
			completed_cmd_pointer_q  <= 4'h0;
			bitcnt_q <= 5'h0;
			dly_q    <= 14'h0;
			shift_q  <= 16'h0;
		end else begin
			case (st_q)
			sq_pkg::ST_IDLE: begin
				if (q_en && !halt_req && !flags_q.mode_fault_flag) begin
					st_q     <= sq_pkg::ST_XFER;
					bitcnt_q <= 5'h0;
				end
			end
			sq_pkg::ST_XFER: begin
				if (sck_rise) begin
					shift_q  <= {shift_q[14:0], miso_sy_q[1]};
					bitcnt_q <= bitcnt_q + 5'h1;
				end
				if (xfer_done) begin
					st_q  <= sq_pkg::ST_DELAY;
					dly_q <= dly_load;
				end
			end
			sq_pkg::ST_DELAY: begin
				dly_q <= dly_q - 14'h1;
				if (cmd_done) begin
					completed_cmd_pointer_q <= cur_q;
					bitcnt_q <= 5'h0;
					if (last_cmd) begin
						cur_q <= 4'h0;
						// halt only here, at queue boundary
						st_q <= halt_req ? sq_pkg::ST_HALTD
							: sq_pkg::ST_IDLE;
					end else begin
						cur_q <= cur_q + 4'h1;
						st_q  <= sq_pkg::ST_XFER;
					end
				end
			end
			sq_pkg::ST_HALTD: begin
				if (!halt_req)
					st_q <= sq_pkg::ST_IDLE;
			end
			default: st_q <= sq_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 16; i++)
				rx_ram_q[i] <= 16'h0;
		end else if (xfer_done) begin
			rx_ram_q[cur_q] <= rjust({shift_q[14:0], miso_sy_q[1]},
				n_bits);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic        aw_hold_q, w_hold_q;
	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	wire  [7:0]  waddr = aw_hold_q ? aw_q : s_axi_awaddr;
	wire  [31:0] wdat  = w_hold_q ? wd_q : s_axi_wdata;
	wire  [3:0]  wstb  = w_hold_q ? ws_q : s_axi_wstrb;
	wire         aw_ok = aw_hold_q | (s_axi_awvalid & s_axi_awready);
	wire         w_ok  = w_hold_q | (s_axi_wvalid & s_axi_wready);
	wire         wr_go = aw_ok & w_ok;
	wire         wr_b0 = wr_go & wstb[0];
	wire         wr_ctl = wr_b0 && waddr == sq_pkg::OFF_CTRL3;
	wire         wr_st  = wr_b0 && waddr == sq_pkg::OFF_STATUS;
	wire         wr_qc  = wr_go && waddr == sq_pkg::OFF_QCFG;
	wire         wr_im  = wr_b0 && waddr == sq_pkg::OFF_IMASK;
	wire  [2:0]  ev_vec = {ev_fin, ev_mode_fault_flag, ev_halt_ack_flag};
	wire  [2:0]  clr_vec = wr_st ? wdat[7:5] : 3'h0;
	wire  [2:0]  fl_d   = (flags_q & ~clr_vec) | ev_vec; // set wins
	wire         irq_d  = (fl_d[2] & imask_q[2])
		| (irq_en & |(fl_d[1:0] & imask_q[1:0]));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_q      <= 8'h00;
			wd_q      <= 32'h0;
			ws_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid & s_axi_awready & ~w_ok) begin
				aw_hold_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready & ~aw_ok) begin
				w_hold_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
	assign s_axi_bresp   = 2'b00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl3_q <= 8'h00;
			qcfg_q  <= 23'h0;
			imask_q <= 3'h0;
			flags_q <= '0;
			irq     <= 1'b0;
		end else begin
			if (wr_ctl)
				ctrl3_q <= wdat[7:0] & sq_pkg::CTL_MASK;
			if (wr_qc)
				qcfg_q <= wdat[22:0];
			if (wr_im)
				imask_q <= wdat[7:5];
			flags_q <= fl_d;
			irq     <= irq_d;
		end
	end

	// read side: full word always returned; byte lanes suit any access size
	wire [7:0]  raddr  = s_axi_araddr;
	wire        rd_ram = raddr[7:6] == sq_pkg::OFF_RXBASE[7:6];
	// word k holds entry 2k low and 2k+1 high; upper half aliases
	wire [31:0] ram_w  = {rx_ram_q[{raddr[4:2], 1'b1}],
		rx_ram_q[{raddr[4:2], 1'b0}]};
	wire [31:0] rd_mux = rd_ram ? ram_w
		: raddr == sq_pkg::OFF_CTRL3  ? {24'h0, ctrl3_q}
		: raddr == sq_pkg::OFF_STATUS ? {24'h0, flags_q, 1'b0, completed_cmd_pointer_q}
		: raddr == sq_pkg::OFF_QCFG   ? {9'h0, qcfg_q}
		: raddr == sq_pkg::OFF_IMASK  ? {24'h0, imask_q, 5'h00}
		: 32'h0;
	wire        rd_bad = !rd_ram && raddr != sq_pkg::OFF_CTRL3
		&& raddr != sq_pkg::OFF_STATUS && raddr != sq_pkg::OFF_QCFG
		&& raddr != sq_pkg::OFF_IMASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_bad ? 2'b10 : 2'b00;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = ~s_axi_rvalid;

	////////////////////////////////////////////////////////////////////////
	// irq follows the enable sampled one edge earlier, except for the fin source, which only imask_q[2] gates
	a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!irq_en |=> !irq || (flags_q.fin && $past(imask_q[2])))
		else $error("irq raised with enable clear");
	a_halt_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == sq_pkg::ST_HALTD && !$past(st_q == sq_pkg::ST_HALTD))
		|-> $past(cmd_done && last_cmd))
		else $error("halt entered off queue boundary");
	a_fin_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_fin |=> flags_q.fin)
		else $error("finished flag not set");
	a_mode_fault_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(master_select_bit && q_en && !ss_sy_q[1]) |=> flags_q.mode_fault_flag)
		else $error("mode fault not flagged");
	a_halt_ack_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == sq_pkg::ST_HALTD && $past(st_q) == sq_pkg::ST_DELAY)
		|-> flags_q.halt_ack_flag)
		else $error("halt ack missing");
	a_ptr_update: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_done |=> completed_cmd_pointer_q == $past(cur_q))
		else $error("pointer not updated");
	a_ptr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!cmd_done |=> $stable(completed_cmd_pointer_q))
		else $error("pointer moved mid command");
	a_std_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		(xfer_done && !dt_sel) |=> dly_q == 14'(sq_pkg::STD_DELAY_CLKS))
		else $error("standard delay wrong");
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(flags_q.fin && !wr_st) |=> flags_q.fin)
		else $error("flag dropped without clear");
	a_mode_fault_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(flags_q.mode_fault_flag && !wr_st) |=> flags_q.mode_fault_flag)
		else $error("mode fault dropped without clear");
	a_halt_ack_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(flags_q.halt_ack_flag && !wr_st) |=> flags_q.halt_ack_flag)
		else $error("halt ack dropped without clear");
	a_user_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		(xfer_done && dt_sel) |=> dly_q == (($past(post_transfer_delay_length) == 8'h00)
		? 14'(sq_pkg::DTL_ZERO_CLKS)
		: 14'(sq_pkg::DTL_SCALE) * {6'h0, $past(post_transfer_delay_length)}))
		else $error("user delay wrong");
	a_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(bits_f == 4'h0) |-> n_bits == 5'(sq_pkg::NBITS_DEFAULT))
		else $error("bits code zero not sixteen");
	a_bits_map: assert property (@(posedge aclk) disable iff (!aresetn)
		bits_f[3] |-> n_bits == 5'(sq_pkg::NBITS_MIN) + {2'h0, bits_f[2:0]})
		else $error("bits code decoded wrong");
	a_rx_upper: assert property (@(posedge aclk) disable iff (!aresetn)
		xfer_done |=> (rx_ram_q[$past(cur_q)] >> $past(n_bits)) == 16'h0)
		else $error("unused receive bits not zero");
	a_halt_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == sq_pkg::ST_HALTD && !halt_req) |=> st_q == sq_pkg::ST_IDLE)
		else $error("halt did not release");
	a_mode_fault_flag_block: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q == sq_pkg::ST_IDLE && flags_q.mode_fault_flag)
		|=> st_q != sq_pkg::ST_XFER)
		else $error("queue started under mode fault");
	a_status_bit4: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && raddr == sq_pkg::OFF_STATUS)
		|=> !s_axi_rdata[4])
		else $error("status bit four not zero");
	a_irq_fault: assert property (@(posedge aclk) disable iff (!aresetn)
		(irq_en && flags_q.mode_fault_flag && imask_q[1] && !wr_st) |=> irq)
		else $error("enabled fault gave no irq");
	a_fin_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(flags_q.fin) |-> $past(ev_fin))
		else $error("finished flag set without last command");
	a_halt_ack_flag_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(flags_q.halt_ack_flag) |-> st_q == sq_pkg::ST_HALTD)
		else $error("halt ack set while running");
	// answers must stand until the master takes them
	a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
		else $error("read response dropped early");
endmodule
`default_nettype wire

// >>> rtl/sq_pkg.sv
package sq_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL3  = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_QCFG   = 8'h08;
	localparam logic [7:0] OFF_IMASK  = 8'h0C;
	localparam logic [7:0] OFF_RXBASE = 8'h40;
	// control three fields
	localparam int CTL_HFIE = 2;
	localparam int CTL_HALT = 0;
	localparam logic [7:0] CTL_MASK = 8'h05;
	// status fields
	localparam int ST_FIN  = 7;
	localparam int ST_MODE_FAULT_FLAG = 6;
	localparam int ST_HALT_ACK_FLAG = 5;
	localparam logic [7:0] ST_FLAGS = 8'hE0;
	// queue config fields
	localparam int QC_ENDQ = 0;
	localparam int QC_DTL  = 8;
	localparam int QC_BITS = 16;
	localparam int QC_DT   = 20;
	localparam int QC_MASTER_SELECT_BIT = 21;
	localparam int QC_EN   = 22;
	// timing and bit counts
	localparam int STD_DELAY_CLKS = 17;
	localparam int DTL_SCALE      = 32;
	localparam int DTL_ZERO_CLKS  = 8192;
	localparam int NBITS_DEFAULT  = 16;
	localparam int NBITS_MIN      = 8;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_XFER  = 4'b0010,
		ST_DELAY = 4'b0100,
		ST_HALTD = 4'b1000
	} q_state_e;
	typedef struct packed {
		logic       fin;
		logic       mode_fault_flag;
		logic       halt_ack_flag;
	} flags_s;
endpackage

// >>> tb/queued_serial_status_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module queued_serial_status_control_tb;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        go, ss_n;
	logic [7:0]  awaddr, araddr, sdata;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	wire         awready, wready, bvalid, arready, rvalid, irq, sck, miso;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	int          bad_count, n_tests, cyc;
	logic [33:0] expq[$];
	logic [7:0]  b[4];

	queued_serial_status_control dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sck_in(sck), .miso_in(miso),
		.ss_n_in(ss_n), .irq(irq));
	serial_slave_model slave (.go(go), .data(sdata), .sck(sck), .miso(miso));

	////////////////////////////////////////////////////////////////////
	task chk(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			if (bh) chk({32'h0, bresp}, 34'h0);
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		logic ah, h;
		expq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		h = 1'b0;
		while (!h) begin
			@(negedge aclk);
			ah = arvalid && arready;
			h = rvalid;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task irq_is(input logic e);
		@(negedge aclk);
		chk({33'h0, irq}, {33'h0, e});
		@(posedge aclk);
	endtask
	task frame(input logic [7:0] d);
		sdata <= d;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (80) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////
	always @(negedge aclk) begin
		if (rvalid && rready && expq.size() > 0) begin
			chk({rresp, rdata}, expq.pop_front());
		end
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
		ss_n = 1'b1;
		{awaddr, araddr, sdata, wdata} = '0;
		wstrb = 4'hF;
		{bad_count, n_tests, cyc} = '0;
		void'($urandom(27));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(sq_pkg::OFF_CTRL3, 34'h0);
		rd(sq_pkg::OFF_STATUS, 34'h0);
		rd(8'h10, {2'b10, 32'h0});
		wr(sq_pkg::OFF_IMASK, 32'hE0);
		// two queue runs of entries 0..1, 8 bits each; halt asked in run 1
		for (int r = 0; r < 2; r++) begin
			wr(sq_pkg::OFF_QCFG, 32'h0068_0001);
			repeat (4) @(posedge aclk);
			b[2*r] = 8'($urandom);
			b[2*r+1] = 8'($urandom);
			frame(b[2*r]);
			if (r == 1) wr(sq_pkg::OFF_CTRL3, 32'h5);
			frame(b[2*r+1]);
			for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
			irq_is(1'b1);
			rd(sq_pkg::OFF_STATUS, r ? 34'hA1 : 34'h81);
			rd(sq_pkg::OFF_RXBASE, {10'h0, b[2*r+1], 8'h0, b[2*r]});
			if (r == 0) begin
				wr(sq_pkg::OFF_QCFG, 32'h0020_0001);
				wr(sq_pkg::OFF_STATUS, 32'h80);
				rd(sq_pkg::OFF_STATUS, 34'h01);
			end
		end
		rd(sq_pkg::OFF_CTRL3, 34'h5);
		wr(sq_pkg::OFF_STATUS, 32'hA0);
		rd(sq_pkg::OFF_STATUS, 34'h01);
		wr(sq_pkg::OFF_CTRL3, 32'h1);
		ss_n <= 1'b0;
		repeat (4) @(posedge aclk);
		ss_n <= 1'b1;
		rd(sq_pkg::OFF_STATUS, 34'h41);
		irq_is(1'b0);
		wr(sq_pkg::OFF_CTRL3, 32'h5);
		repeat (2) @(posedge aclk);
		irq_is(1'b1);
		wr(sq_pkg::OFF_STATUS, 32'h40);
		rd(sq_pkg::OFF_STATUS, 34'h01);
		irq_is(1'b0);
		// slave run: 16-bit code, user delay of one unit, restart from halt
		wr(sq_pkg::OFF_QCFG, 32'h0050_0100);
		wr(sq_pkg::OFF_CTRL3, 32'h4);
		repeat (4) @(posedge aclk);
		b[0] = 8'($urandom);
		b[1] = 8'($urandom);
		frame(b[0]);
		frame(b[1]);
		for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
		irq_is(1'b1);
		rd(sq_pkg::OFF_STATUS, 34'h80);
		rd(sq_pkg::OFF_RXBASE, {10'h0, b[3], b[0], b[1]});
		finish_test;
	end
endmodule
`default_nettype wire

// >>> tb/serial_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module serial_slave_model (
	input  wire logic       go,   // start one 8-bit frame
	input  wire logic [7:0] data, // word to shift out
	output logic            sck,  // link clock, still between frames
	output logic            miso  // serial data to the controller
);
	initial begin
		sck = 1'b0;
		miso = 1'b1;
	end
	// msb first, data changes while sck is low
	always @(posedge go) begin
		#1;
		for (int i = 7; i >= 0; i--) begin
			miso = data[i];
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
		// released line shows the inverse, never a stale bit
		miso = ~data[0];
	end
endmodule
`default_nettype wire
